// File: imsc_regs.svh
`ifndef IMSC_REGS_SVH
`define IMSC_REGS_SVH
// ==========================================
// register addresses (hex register numbers of the serial port map)
`define IMSC_ADDR_CAL_CTRL 8'h88
`define IMSC_ADDR_LOSS_HI 8'h8A
`define IMSC_ADDR_MON_EN 8'h8B
`define IMSC_ADDR_SKEW1 8'h8C
`define IMSC_ADDR_SKEW2 8'h8D
`define IMSC_ADDR_SKEW3 8'h8E
`define IMSC_ADDR_SKEW4 8'h8F
`define IMSC_ADDR_SKEW5 8'h90
`define IMSC_ADDR_OUT_CTRL 8'h91
// ==========================================
// field positions
`define IMSC_CAL_START_BIT 6
`define IMSC_SIGLOSS_LO_POS 4
`define IMSC_FREQ_OFS_POS 0
`define IMSC_NEVER_SQ_BIT 0
`define IMSC_CAL_SQ_BIT 1
`define IMSC_CFG_SEL_POS 4
// ==========================================
// reset values
`define IMSC_RST_LOSS_HI 8'h0F
`define IMSC_RST_MON_EN 8'hFF
`define IMSC_RST_SKEW1 8'h00
`define IMSC_RST_SKEW2 8'h01
`define IMSC_RST_SKEW3 8'h00
`define IMSC_RST_SKEW4 8'h00
`define IMSC_RST_SKEW5 8'h00
`define IMSC_RST_OUT_CTRL 8'h00
// ==========================================
// timing: calibration must run at least this long before lock is trusted
`define IMSC_CAL_MIN_NS 1000
`define IMSC_CLK_NS 100
`define IMSC_CAL_MIN_CYC ((`IMSC_CAL_MIN_NS + `IMSC_CLK_NS - 1) / `IMSC_CLK_NS)
`endif

// File: imsc_pkg.sv
`default_nettype none
package imsc_pkg;
    typedef enum logic [1:0] {
        IMSC_SL_OFF,
        IMSC_SL_RSVD,
        IMSC_SL_SLOW,
        IMSC_SL_FAST
    } imsc_sigloss_e;
    typedef enum logic [1:0] {
        IMSC_CAL_IDLE,
        IMSC_CAL_RUN,
        IMSC_CAL_WAIT_LOCK
    } imsc_cal_e;
    typedef logic signed [7:0] imsc_skew_t;
endpackage
`default_nettype wire

// File: imsc_out_gate.sv
`include "imsc_regs.svh"
`default_nettype none
module imsc_out_gate
    import imsc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // controls
    input wire logic outputsNeverSquelched,
    input wire logic calibrationSquelch,
    input wire logic calDone,
    input wire logic calBusy,
    input wire logic lossOfLockAlarm,
    // result
    output logic clockOutputsOn,
    output logic skewPreserved
);
    logic firstCalSeen;
    logic firstGoodCal;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            firstCalSeen <= 1'b0;
            firstGoodCal <= 1'b0;
        end else begin
            if (calDone) begin
                firstCalSeen <= 1'b1;
            end
            if (calDone && !lossOfLockAlarm) begin
                firstGoodCal <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            clockOutputsOn <= 1'b0;
            skewPreserved <= 1'b0;
        end else begin
            if (outputsNeverSquelched) begin
                clockOutputsOn <= 1'b1; // see RULE_09
            end else if (calibrationSquelch) begin
                clockOutputsOn <= firstGoodCal && !calBusy; // see RULE_08
            end else begin
                clockOutputsOn <= firstCalSeen; // see RULE_07
            end
            skewPreserved <= calibrationSquelch; // see RULE_07 see RULE_08 see RULE_09
        end
    end
endmodule
`default_nettype wire

// File: imsc_config.sv
// ==========================================
// Functional notes
// RULE_01: each input's signal-loss select is two bits, 00 off, 01 reserved, 10 slow monitor, 11 fast monitor.
// RULE_02: the slow monitor is a slower, less sensitive variant of the fast one on the same input.
// RULE_03: one bit per input turns its frequency-offset check off (0) or on (1).
// RULE_04: each of five outputs has an 8-bit signed skew counted in high-speed divider clocks.
// RULE_05: the fifth output's skew only applies while the output configuration selector is 0.
// RULE_06: after reset skew2 reads 0x01 and skews 1, 3, 4 and 5 read 0x00.
// RULE_07: never-squelched 0 and squelch 0 keeps outputs off until the first calibration, skew not kept.
// RULE_08: never-squelched 0 and squelch 1 keeps outputs off until a calibration ends with lock, skew kept.
// RULE_09: never-squelched 1 runs outputs always; skew is kept only with squelch 1.
// RULE_10: software should recalibrate after changing bandwidth, dividers, rates and similar settings.
// RULE_11: the calibration start bit self-clears when calibration ends, signalled by lock loss going low.
// RULE_12: every enable and skew field reads back what was last written, or its reset default.
`include "imsc_regs.svh"
`default_nettype none
module imsc_config
    import imsc_pkg::*;
#(
    parameter int NUM_IN = 4,
    parameter int NUM_OUT = 5,
    parameter int CAL_MIN_CYC = `IMSC_CAL_MIN_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // register port from the serial management interface
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    output logic [7:0] regRdata,
    // pll status
    input wire logic lossOfLockAlarm,
    // monitor controls
    output logic [2*NUM_IN-1:0] sigLossMonSel,
    output logic [NUM_IN-1:0] slowSiglossMonitor,
    output logic [NUM_IN-1:0] fastSiglossMonitor,
    output logic [NUM_IN-1:0] freqOffsetCheck,
    // output controls
    output logic [8*NUM_OUT-1:0] phaseSkew,
    output logic [NUM_OUT-1:0] skewApply,
    output logic selfCalibration,
    output logic clockOutputsOn,
    output logic skewPreserved
);
    // ==========================================
    // storage
    logic [NUM_IN-1:0] lossHi;
    logic [7:0] monEn;
    logic [7:0] skew [NUM_OUT];
    logic [7:0] outCtrl;
    logic calStart;
    imsc_cal_e calState;
    logic [15:0] calCount;
    logic calDone;
    logic [7:0] next_rdata;

    // ==========================================
    // write strobes, one per register, except one strobe shared by the five skew registers
    logic wrCalCtrl;
    logic wrLossHi;
    logic wrMonEn;
    logic wrOutCtrl;
    logic wrSkew;
    logic [2:0] skewIdx;

    assign wrCalCtrl = regWrite && (regAddr == `IMSC_ADDR_CAL_CTRL);
    assign wrLossHi = regWrite && (regAddr == `IMSC_ADDR_LOSS_HI);
    assign wrMonEn = regWrite && (regAddr == `IMSC_ADDR_MON_EN);
    assign wrOutCtrl = regWrite && (regAddr == `IMSC_ADDR_OUT_CTRL);
    assign wrSkew = regWrite && (regAddr >= `IMSC_ADDR_SKEW1) && (regAddr <= `IMSC_ADDR_SKEW5);
    // the skew block spans five addresses, so three offset bits are enough
    assign skewIdx = 3'(regAddr - `IMSC_ADDR_SKEW1);

    // ==========================================
    // register writes, one process per register, except one process shared by the five skew registers
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lossHi <= NUM_IN'(`IMSC_RST_LOSS_HI);
        end else if (wrLossHi) begin
            lossHi <= regWdata[NUM_IN-1:0]; // see RULE_12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            monEn <= `IMSC_RST_MON_EN;
        end else if (wrMonEn) begin
            monEn <= regWdata; // see RULE_12
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            outCtrl <= `IMSC_RST_OUT_CTRL;
        end else if (wrOutCtrl) begin
            outCtrl <= regWdata;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            skew[0] <= `IMSC_RST_SKEW1; // see RULE_06
            skew[1] <= `IMSC_RST_SKEW2;
            skew[2] <= `IMSC_RST_SKEW3;
            skew[3] <= `IMSC_RST_SKEW4;
            skew[4] <= `IMSC_RST_SKEW5;
        end else if (wrSkew) begin
            skew[skewIdx] <= regWdata; // see RULE_12
        end
    end

    // ==========================================
    // per-input and per-output decode
    genvar gi;
    generate
        for (gi = 0; gi < NUM_IN; gi++) begin : g_in
            logic [1:0] sel;
            assign sel = {lossHi[gi], monEn[`IMSC_SIGLOSS_LO_POS + gi]};
            assign sigLossMonSel[2*gi +: 2] = sel;
            // reserved code enables nothing; slow variant is a separate, less sensitive detector
            assign slowSiglossMonitor[gi] = (sel == IMSC_SL_SLOW); // see RULE_01 see RULE_02
            assign fastSiglossMonitor[gi] = (sel == IMSC_SL_FAST); // see RULE_01
            assign freqOffsetCheck[gi] = monEn[`IMSC_FREQ_OFS_POS + gi]; // see RULE_03
        end
        for (gi = 0; gi < NUM_OUT; gi++) begin : g_out
            assign phaseSkew[8*gi +: 8] = skew[gi]; // see RULE_04
            if (gi == NUM_OUT - 1) begin : g_last
                assign skewApply[gi] = (outCtrl[`IMSC_CFG_SEL_POS +: 2] == 2'h0); // see RULE_05
            end else begin : g_other
                assign skewApply[gi] = 1'b1;
            end
        end
    endgenerate

    // ==========================================
    // calibration sequencer
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            calState <= IMSC_CAL_IDLE;
            calCount <= 16'h0000;
            calStart <= 1'b0;
        end else begin
            case (calState)
                IMSC_CAL_IDLE: begin
                    if (wrCalCtrl && regWdata[`IMSC_CAL_START_BIT]) begin
                        calStart <= 1'b1;
                        calCount <= 16'h0000;
                        calState <= IMSC_CAL_RUN;
                    end
                end
                IMSC_CAL_RUN: begin
                    calCount <= calCount + 16'h0001;
                    if (calCount >= 16'(CAL_MIN_CYC - 1)) begin
                        calState <= IMSC_CAL_WAIT_LOCK;
                    end
                end
                IMSC_CAL_WAIT_LOCK: begin
                    // lock only trusted after the minimum run, so a stale low alarm cannot end it early
                    if (!lossOfLockAlarm) begin
                        calStart <= 1'b0; // see RULE_11
                        calState <= IMSC_CAL_IDLE;
                    end
                end
                default: begin
                    calState <= IMSC_CAL_IDLE;
                end
            endcase
        end
    end

    assign calDone = (calState == IMSC_CAL_WAIT_LOCK) && !lossOfLockAlarm;
    assign selfCalibration = calStart;

    imsc_out_gate u_gate (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .outputsNeverSquelched(outCtrl[`IMSC_NEVER_SQ_BIT]),
        .calibrationSquelch(outCtrl[`IMSC_CAL_SQ_BIT]),
        .calDone(calDone),
        .calBusy(calStart),
        .lossOfLockAlarm(lossOfLockAlarm),
        .clockOutputsOn(clockOutputsOn),
        .skewPreserved(skewPreserved)
    );

    // ==========================================
    // read mux, registered
    always_comb begin
        next_rdata = 8'h00;
        case (regAddr)
            `IMSC_ADDR_CAL_CTRL: begin
                next_rdata[`IMSC_CAL_START_BIT] = calStart;
            end
            `IMSC_ADDR_LOSS_HI: begin
                next_rdata[NUM_IN-1:0] = lossHi;
            end
            `IMSC_ADDR_MON_EN: begin
                next_rdata = monEn;
            end
            `IMSC_ADDR_SKEW1: begin
                next_rdata = skew[0];
            end
            `IMSC_ADDR_SKEW2: begin
                next_rdata = skew[1];
            end
            `IMSC_ADDR_SKEW3: begin
                next_rdata = skew[2];
            end
            `IMSC_ADDR_SKEW4: begin
                next_rdata = skew[3];
            end
            `IMSC_ADDR_SKEW5: begin
                next_rdata = skew[4];
            end
            `IMSC_ADDR_OUT_CTRL: begin
                next_rdata = outCtrl;
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else begin
            regRdata <= next_rdata;
        end
    end
endmodule
`default_nettype wire

// File: imsc_config_props.sv
`default_nettype none
module imsc_config_props #(
    parameter int CAL_MIN_CYC = 10
) (
    // clock, reset, register port and pll status
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] regAddr,
    input wire logic regWrite,
    input wire logic [7:0] regWdata,
    input wire logic [7:0] regRdata,
    input wire logic lossOfLockAlarm,
    // controls driven by the block
    input wire logic [7:0] sigLossMonSel,
    input wire logic [3:0] slowSiglossMonitor,
    input wire logic [3:0] fastSiglossMonitor,
    input wire logic [3:0] freqOffsetCheck,
    input wire logic [39:0] phaseSkew,
    input wire logic [4:0] skewApply,
    input wire logic selfCalibration,
    input wire logic clockOutputsOn,
    input wire logic skewPreserved
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] expSlow;
    logic [3:0] expFast;
    logic [7:0] lockedRun;
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            expSlow[n] = sigLossMonSel[2*n+:2] == 2'b10;
            expFast[n] = sigLossMonSel[2*n+:2] == 2'b11;
        end
    end
    // cycles of calibration with lock already good; must stay short
    always_ff @(posedge sys_clk) begin
        if (!rst_n || !selfCalibration || lossOfLockAlarm) begin
            lockedRun <= 8'h00;
        end else begin
            lockedRun <= lockedRun + 8'h01;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    chk_slow_code: assert property (slowSiglossMonitor == expSlow)
        else $error("slow monitor select wrong");
    chk_fast_code: assert property (fastSiglossMonitor == expFast)
        else $error("fast monitor select wrong");
    chk_fos_write: assert property (regWrite && regAddr == 8'h8B |=> freqOffsetCheck == $past(regWdata[3:0]))
        else $error("frequency check enable wrong");
    chk_skew_write: assert property (regWrite && regAddr == 8'h8D |=> phaseSkew[15:8] == $past(regWdata))
        else $error("skew output wrong");
    chk_fifth_apply: assert property (regWrite && regAddr == 8'h91 |=> skewApply == {$past(regWdata[5:4]) == 2'b00, 4'hF})
        else $error("skew apply wrong");
    chk_cal_start: assert property (regWrite && regAddr == 8'h88 && regWdata[6] && !selfCalibration |=> selfCalibration[*3])
        else $error("calibration did not start");
    chk_cal_bound: assert property (lockedRun <= CAL_MIN_CYC + 2)
        else $error("calibration did not end on lock");
    chk_never_sq: assert property (regWrite && regAddr == 8'h91 && regWdata[0] |-> ##[1:2] clockOutputsOn)
        else $error("outputs not forced on");
    chk_skew_kept: assert property (regWrite && regAddr == 8'h91 |=> ##1 skewPreserved == $past(regWdata[1], 2))
        else $error("skew preserved flag wrong");
    chk_unmapped_read: assert property (regAddr == 8'h89 |=> regRdata == 8'h00)
        else $error("unmapped read not zero");
    cover property ($fell(selfCalibration));
    cover property ($rose(clockOutputsOn));
    cover property (slowSiglossMonitor != 4'h0 && fastSiglossMonitor != 4'h0);
endmodule
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] regAddr = 8'h00;
    logic regWrite = 1'b0;
    logic [7:0] regWdata = 8'h00;
    logic lossOfLockAlarm = 1'b1;
    logic pend = 1'b0;
    logic [7:0] regRdata, sigLossMonSel, d;
    logic [3:0] slowSiglossMonitor, fastSiglossMonitor, freqOffsetCheck;
    logic [39:0] phaseSkew, expSkew;
    logic [4:0] skewApply;
    logic selfCalibration, clockOutputsOn, skewPreserved;
    int numErrors = 0;
    int totalChecks = 0;
    string nmQ[$];
    logic [39:0] expQ[$];
    logic [7:0] rstAddr[8] = '{8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E, 8'h8F, 8'h90, 8'h89};
    logic [7:0] rstVal[8] = '{8'h0F, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};
    logic [7:0] ctls[4] = '{8'h00, 8'h02, 8'h01, 8'h03};
    always #50 sys_clk = ~sys_clk;
    imsc_config #(.CAL_MIN_CYC(3)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .regAddr(regAddr), .regWrite(regWrite),
        .regWdata(regWdata), .regRdata(regRdata), .lossOfLockAlarm(lossOfLockAlarm), .sigLossMonSel(sigLossMonSel),
        .slowSiglossMonitor(slowSiglossMonitor), .fastSiglossMonitor(fastSiglossMonitor),
        .freqOffsetCheck(freqOffsetCheck), .phaseSkew(phaseSkew), .skewApply(skewApply),
        .selfCalibration(selfCalibration), .clockOutputsOn(clockOutputsOn), .skewPreserved(skewPreserved));
    // ==========================================
    // result watcher
    always @(negedge sys_clk) begin
        string nm;
        logic [39:0] e, got;
        if (pend && nmQ.size() > 0) begin
            nm = nmQ.pop_front();
            e = expQ.pop_front();
            case (nm)
                "skew": got = phaseSkew;
                "mon": got = {20'h0_0000, sigLossMonSel, slowSiglossMonitor, fastSiglossMonitor, freqOffsetCheck};
                "outs": got = {32'h0000_0000, skewApply, selfCalibration, clockOutputsOn, skewPreserved};
                default: got = {32'h0000_0000, regRdata};
            endcase
            totalChecks++;
            if (got !== e) begin
                numErrors++;
                $display("ERROR %s expected %h seen %h", nm, e, got);
            end
        end
    end
    // ==========================================
    // drivers
    task automatic finalReport();
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        pend <= 1'b0;
        @(posedge sys_clk);
        regWrite <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [7:0] a, input logic [39:0] e);
        @(posedge sys_clk);
        regAddr <= a;
        pend <= 1'b0;
        nmQ.push_back(nm);
        expQ.push_back(e);
        @(posedge sys_clk);
        pend <= 1'b1;
    endtask
    task automatic doReset();
        @(posedge sys_clk);
        rst_n <= 1'b0;
        lossOfLockAlarm <= 1'b1;
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
    endtask
    // one first calibration under a given output control setting
    task automatic runCal(input logic [7:0] c);
        int i;
        doReset();
        wr(8'h91, c);
        chk("outs", 8'h88, {32'h0000_0000, 5'h1F, 1'b0, c[0], c[1]});
        wr(8'h88, 8'h40);
        repeat (5) @(posedge sys_clk);
        chk("outs", 8'h88, {32'h0000_0000, 5'h1F, 1'b1, c[0], c[1]});
        lossOfLockAlarm <= 1'b0;
        for (i = 0; i < 50 && selfCalibration !== 1'b0; i++) @(negedge sys_clk);
        if (i == 50) begin
            numErrors++;
            finalReport();
        end
        chk("outs", 8'h88, {32'h0000_0000, 5'h1F, 1'b0, 1'b1, c[1]});
        chk("rd", 8'h88, 40'h00_0000_0000);
        $display("calibration test %h done", c);
    endtask
    initial begin
        d = 8'($urandom(32'h3249_520d));
        doReset();
        for (int n = 0; n < 8; n++) chk("rd", rstAddr[n], {32'h0000_0000, rstVal[n]});
        chk("skew", 8'h00, 40'h00_0000_0100);
        expSkew = 40'h00_0000_0100;
        for (int n = 0; n < 5; n++) begin
            d = 8'($urandom);
            expSkew[8*n+:8] = d;
            wr(8'(8'h8C + n), d);
        end
        for (int n = 0; n < 5; n++) chk("rd", 8'(8'h8C + n), {32'h0000_0000, expSkew[8*n+:8]});
        chk("skew", 8'h00, expSkew);
        wr(8'h89, 8'hFF);
        chk("rd", 8'h89, 40'h00_0000_0000);
        $display("register test done");
        wr(8'h8A, 8'h0C);
        wr(8'h8B, 8'hA6);
        chk("mon", 8'h8A, 40'h00_000E_4486);
        chk("rd", 8'h8B, 40'h00_0000_00A6);
        $display("monitor test done");
        for (int s = 3; s >= 0; s--) begin
            wr(8'h91, {2'b00, 2'(s), 4'h0});
            chk("outs", 8'h91, {32'h0000_0000, s == 0, 4'hF, 3'b000});
        end
        $display("skew apply test done");
        foreach (ctls[k]) runCal(ctls[k]);
        finalReport();
    end
endmodule
bind imsc_config imsc_config_props #(.CAL_MIN_CYC(CAL_MIN_CYC)) u_props (.sys_clk(sys_clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWrite(regWrite), .regWdata(regWdata), .regRdata(regRdata),
    .lossOfLockAlarm(lossOfLockAlarm), .sigLossMonSel(sigLossMonSel), .slowSiglossMonitor(slowSiglossMonitor),
    .fastSiglossMonitor(fastSiglossMonitor), .freqOffsetCheck(freqOffsetCheck), .phaseSkew(phaseSkew),
    .skewApply(skewApply), .selfCalibration(selfCalibration), .clockOutputsOn(clockOutputsOn),
    .skewPreserved(skewPreserved));
`default_nettype wire
